// [verilog/fprid_pkg.sv]
// Shared constants and types for the flash sleep, read-parameter and identify command block
package fprid_pkg;
  // Command opcodes
  localparam logic [7:0] OP_ENTER_SLEEP = 8'hb9; // enter_sleep_cmd
  localparam logic [7:0] OP_RELEASE_SLEEP = 8'hab; // release_sleep_cmd and legacy_identify_cmd
  localparam logic [7:0] OP_SET_RD_PERSIST = 8'h65; // set_read_params_persistent
  localparam logic [7:0] OP_SET_RD_TEMP_A = 8'hc0; // set_read_params_temporary
  localparam logic [7:0] OP_SET_RD_TEMP_B = 8'h63; // set_read_params_temporary, alias
  localparam logic [7:0] OP_SET_EXT_PERSIST = 8'h85; // set_ext_params_persistent
  localparam logic [7:0] OP_SET_EXT_TEMP = 8'h83; // set_ext_params_temporary
  localparam logic [7:0] OP_QUERY_RD = 8'h61; // query_read_params
  localparam logic [7:0] OP_QUERY_EXT = 8'h81; // query_ext_params
  // Read parameter field layout
  localparam int WRAP_SIZE_LSB = 0; // wrap_size_bit1..bit0
  localparam int WRAP_SIZE_W = 2;
  localparam int WRAP_EN_BIT = 2; // wrap_enable
  localparam int DUMMY_LSB = 3; // dummy_count_bit3..bit0
  localparam int DUMMY_W = 4;
  localparam int PIN_SEL_BIT = 7; // hold_reset_pin_select
  localparam int EXT_W = 3; // drive_strength_bit2..bit0
  // Reset values
  localparam logic [7:0] RD_PARAM_DEFAULT = 8'h00;
  localparam logic [2:0] EXT_PARAM_DEFAULT = 3'h5; // Encoding taken as the 50 percent drive step
  localparam logic [7:0] DEVICE_ID_DEFAULT = 8'h5a; // Arbitrary identifier value
  // Address and wrap geometry
  localparam int ADDR_W = 24;
  localparam logic [ADDR_W-1:0] WRAP_MIN_BYTES = 24'h000008; // Smallest wrap window
  localparam int WIN_MAX_LSB = 6; // Bits above this never change inside any window
  // Pin synchroniser layout
  localparam int PIN_SCK = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_STRAP = 2;
  localparam int PIN_IO_LSB = 3;
  localparam int PIN_W = 7;
  localparam logic [PIN_W-1:0] PIN_RESET = 7'h02; // Chip select idles high
  localparam logic [3:0] SO_MASK = 4'h2; // Serial output line in single-bit mode
  localparam logic [3:0] QUAD_MASK = 4'hf;
  localparam logic [1:0] ID_DUMMY_LAST = 2'h2; // Third dummy byte
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SLEEP_ENTRY_TIME_NS = 3000; // sleep_entry_time
  localparam int WAKE_RECOVERY_TIME_NS = 5000; // wake_recovery_time
  localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   SLEEP_ENTRY_TIME_NS / CLK_PERIOD_NS;
  localparam int WAKE_RECOVERY_CYC = (WAKE_RECOVERY_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                                     WAKE_RECOVERY_TIME_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 8;
  localparam logic [TMR_W-1:0] SLEEP_TMR_LOAD = TMR_W'(SLEEP_ENTRY_CYC);
  localparam logic [TMR_W-1:0] WAKE_TMR_LOAD = TMR_W'(WAKE_RECOVERY_CYC);
  localparam logic [TMR_W-1:0] TMR_LAST = 8'h01;
  // Command sequencer states
  typedef enum logic [2:0] {ST_OPC, ST_PARAM, ST_DUMMY, ST_SEND, ST_DONE, ST_IGNORE} fprid_state_t;
endpackage

// [verilog/fprid_wrap_if.sv]
// Carrier between the command block and its read address stepper
interface fprid_wrap_if;
  logic [fprid_pkg::ADDR_W-1:0] cur_addr; // Present read address
  logic wrap_en; // Wrap window active
  logic [fprid_pkg::WRAP_SIZE_W-1:0] wrap_size; // Window size code
  logic [fprid_pkg::ADDR_W-1:0] next_addr; // Following read address
  modport owner (output cur_addr, output wrap_en, output wrap_size, input next_addr);
  modport calc (input cur_addr, input wrap_en, input wrap_size, output next_addr);
endinterface

// [verilog/fprid_wrap.sv]
// Next read address, either linear or wrapped inside an aligned window
module fprid_wrap (
  fprid_wrap_if.calc wif
);
  logic [fprid_pkg::ADDR_W-1:0] win_mask; // Low bits that move inside the window
  logic [fprid_pkg::ADDR_W-1:0] inc_addr; // Plain increment over the whole array

  // Window of 8, 16, 32 or 64 bytes, always inside one page
  assign win_mask = (fprid_pkg::WRAP_MIN_BYTES << wif.wrap_size) - 24'h000001;
  assign inc_addr = wif.cur_addr + 24'h000001;
  // Upper bits held, low bits roll back to window start
  assign wif.next_addr = wif.wrap_en ? ((wif.cur_addr & ~win_mask) | (inc_addr & win_mask))
                                     : inc_addr;
endmodule

// [verilog/fprid_top.sv]
// Sleep, read-parameter, extended-parameter and legacy identify command handling of a serial flash
module fprid_top #(
  parameter logic [7:0] DEVICE_ID = fprid_pkg::DEVICE_ID_DEFAULT // Arbitrary identifier value
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic [3:0] io_in,
  input wire logic quad_mode_in,
  input wire logic write_in_progress_in,
  input wire logic dedicated_reset_pin_in,
  input wire logic rd_start_in,
  input wire logic [fprid_pkg::ADDR_W-1:0] rd_start_addr_in,
  input wire logic rd_step_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_out,
  output logic asleep_out,
  output logic busy_out,
  output logic [7:0] read_params_out,
  output logic [fprid_pkg::EXT_W-1:0] ext_params_out,
  output logic shared_pin_reset_out,
  output logic [fprid_pkg::ADDR_W-1:0] rd_addr_out
);
  // Pin synchronisers
  logic [fprid_pkg::PIN_W-1:0] pins_raw; // All pins gathered
  logic [fprid_pkg::PIN_W-1:0] sync1_reg; // First stage, read only by second
  logic [fprid_pkg::PIN_W-1:0] sync2_reg; // Second stage, safe to use
  logic sck_prev_reg; // Clock level one cycle ago
  logic cs_prev_reg; // Select level one cycle ago
  // Receive path
  logic [7:0] shift_reg; // Incoming bits
  logic [2:0] bit_cnt_reg; // Position inside byte
  // Sequencer
  fprid_pkg::fprid_state_t st_reg; // Command progress
  logic [7:0] opcode_reg; // Latched opcode
  logic [7:0] param_reg; // Latched parameter byte
  logic [1:0] dummy_cnt_reg; // Identify dummy bytes seen
  // Transmit path
  logic [7:0] tx_src_reg; // Byte to repeat
  logic [7:0] tx_reg; // Byte being shifted out
  logic [2:0] tx_cnt_reg; // Position inside outgoing byte
  logic [3:0] io_out_reg; // Driven data
  logic [3:0] io_oe_reg; // Driven enables
  // Power state
  logic asleep_reg; // Low-power state reached
  logic busy_reg; // Entry or recovery running
  logic entering_reg; // Running timer is for entry
  logic [fprid_pkg::TMR_W-1:0] tmr_reg; // Cycles left
  // Parameter registers
  logic [7:0] nv_rd_reg; // Persistent read parameters
  logic [7:0] vol_rd_reg; // Working read parameters
  logic [fprid_pkg::EXT_W-1:0] nv_ext_reg; // Persistent drive strength
  logic [fprid_pkg::EXT_W-1:0] vol_ext_reg; // Working drive strength
  logic reload_reg; // Copy persistent into working once
  logic pin_reset_reg; // Shared pin acts as reset
  logic [fprid_pkg::ADDR_W-1:0] rd_addr_reg; // Read address pointer

  // Decoded strobes
  logic sck_s; // Synchronised serial clock
  logic cs_n_s; // Synchronised select
  logic strap_s; // Synchronised variant strap
  logic [3:0] io_s; // Synchronised data lines
  logic sck_rise, sck_fall, cs_act, cs_rise;
  logic last_bit, byte_done;
  logic [7:0] in_byte;
  logic op_is_ab, op_is_set, op_is_query, op_ok;
  fprid_pkg::fprid_state_t op_next;
  logic load_query, load_id, tx_load, tx_last;
  logic [7:0] tx_load_val, tx_shifted;
  logic end_sleep, end_wake, end_set, sleep_done;

  fprid_wrap_if wif ();

  // Address stepper
  fprid_wrap u_wrap (
    .wif(wif)
  );

  assign pins_raw = {io_in, dedicated_reset_pin_in, cs_n_in, sck_in};

  // Two flip-flops per pin before any logic looks at it
  for (genvar gi = 0; gi < fprid_pkg::PIN_W; gi++) begin : g_sync
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        sync1_reg[gi] <= fprid_pkg::PIN_RESET[gi];
        sync2_reg[gi] <= fprid_pkg::PIN_RESET[gi];
      end else begin
        sync1_reg[gi] <= pins_raw[gi];
        sync2_reg[gi] <= sync1_reg[gi];
      end
    end
  end

  assign sck_s = sync2_reg[fprid_pkg::PIN_SCK];
  assign cs_n_s = sync2_reg[fprid_pkg::PIN_CS];
  assign strap_s = sync2_reg[fprid_pkg::PIN_STRAP];
  assign io_s = sync2_reg[fprid_pkg::PIN_IO_LSB +: 4];

  // Edge history
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sck_prev_reg <= 1'h0;
      cs_prev_reg <= 1'h1;
    end else begin
      sck_prev_reg <= sck_s;
      cs_prev_reg <= cs_n_s;
    end
  end

  assign sck_rise = sck_s & ~sck_prev_reg;
  assign sck_fall = ~sck_s & sck_prev_reg;
  assign cs_act = ~cs_n_s;
  assign cs_rise = cs_n_s & ~cs_prev_reg;

  // Byte framing, nibble pairs in quad mode
  assign last_bit = quad_mode_in ? (bit_cnt_reg == 3'h1) : (bit_cnt_reg == 3'h7);
  assign in_byte = quad_mode_in ? {shift_reg[3:0], io_s} : {shift_reg[6:0], io_s[0]};
  assign byte_done = cs_act & sck_rise & last_bit;

  // Shift in on rising serial clock
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
    end else if (!cs_act) begin
      bit_cnt_reg <= 3'h0;
    end else if (sck_rise) begin
      shift_reg <= in_byte;
      bit_cnt_reg <= last_bit ? 3'h0 : bit_cnt_reg + 3'h1;
    end
  end

  // Opcode classification
  assign op_is_ab = (in_byte == fprid_pkg::OP_RELEASE_SLEEP);
  assign op_is_set = (in_byte == fprid_pkg::OP_SET_RD_PERSIST) | (in_byte == fprid_pkg::OP_SET_RD_TEMP_A) |
                     (in_byte == fprid_pkg::OP_SET_RD_TEMP_B) | (in_byte == fprid_pkg::OP_SET_EXT_PERSIST) |
                     (in_byte == fprid_pkg::OP_SET_EXT_TEMP);
  assign op_is_query = (in_byte == fprid_pkg::OP_QUERY_RD) | (in_byte == fprid_pkg::OP_QUERY_EXT);
  // Busy windows refuse all; asleep only release; release refused during a write
  assign op_ok = ~busy_reg & (~asleep_reg | op_is_ab) & ~(op_is_ab & write_in_progress_in);
  assign op_next = !op_ok ? fprid_pkg::ST_IGNORE :
                   (in_byte == fprid_pkg::OP_ENTER_SLEEP) ? fprid_pkg::ST_DONE :
                   op_is_ab ? fprid_pkg::ST_DUMMY :
                   op_is_set ? fprid_pkg::ST_PARAM :
                   op_is_query ? fprid_pkg::ST_SEND : fprid_pkg::ST_IGNORE;

  // Command sequencer, restarted by every deselect
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_reg <= fprid_pkg::ST_OPC;
      opcode_reg <= 8'h00;
      param_reg <= 8'h00;
      dummy_cnt_reg <= 2'h0;
    end else if (!cs_act) begin
      st_reg <= fprid_pkg::ST_OPC;
      dummy_cnt_reg <= 2'h0;
    end else if (sck_rise) begin
      unique case (st_reg)
        // Opcode byte
        fprid_pkg::ST_OPC: begin
          if (last_bit) begin
            st_reg <= op_next;
            opcode_reg <= in_byte;
          end
        end
        // Parameter data byte, bit for bit
        fprid_pkg::ST_PARAM: begin
          if (last_bit) begin
            st_reg <= fprid_pkg::ST_DONE;
            param_reg <= in_byte;
          end
        end
        // Three dummy bytes before the identifier
        fprid_pkg::ST_DUMMY: begin
          if (last_bit) begin
            dummy_cnt_reg <= dummy_cnt_reg + 2'h1;
            if (dummy_cnt_reg == fprid_pkg::ID_DUMMY_LAST) begin
              st_reg <= fprid_pkg::ST_SEND;
            end
          end
        end
        // Any clock past a complete command spoils it
        fprid_pkg::ST_DONE: st_reg <= fprid_pkg::ST_IGNORE;
        // Output and ignore phases wait for deselect
        fprid_pkg::ST_SEND, fprid_pkg::ST_IGNORE: st_reg <= st_reg;
      endcase
    end
  end

  // Transmit byte selection, queries read the persistent copies
  assign load_query = byte_done & (st_reg == fprid_pkg::ST_OPC) & (op_next == fprid_pkg::ST_SEND);
  assign load_id = byte_done & (st_reg == fprid_pkg::ST_DUMMY) & (dummy_cnt_reg == fprid_pkg::ID_DUMMY_LAST);
  assign tx_load = load_query | load_id;
  assign tx_load_val = load_id ? DEVICE_ID :
                       (in_byte == fprid_pkg::OP_QUERY_RD) ? nv_rd_reg :
                       {5'h00, nv_ext_reg};
  assign tx_last = quad_mode_in ? (tx_cnt_reg == 3'h1) : (tx_cnt_reg == 3'h7);
  assign tx_shifted = quad_mode_in ? {tx_reg[3:0], 4'h0} : {tx_reg[6:0], 1'h0};

  // Shift out on falling serial clock, byte repeats while selected
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_src_reg <= 8'h00;
      tx_reg <= 8'h00;
      tx_cnt_reg <= 3'h0;
      io_out_reg <= 4'h0;
      io_oe_reg <= 4'h0;
    end else if (!cs_act) begin
      tx_cnt_reg <= 3'h0;
      io_oe_reg <= 4'h0;
    end else if (tx_load) begin
      tx_src_reg <= tx_load_val;
      tx_reg <= tx_load_val;
      tx_cnt_reg <= 3'h0;
    end else if ((st_reg == fprid_pkg::ST_SEND) && sck_fall) begin
      io_out_reg <= quad_mode_in ? tx_reg[7:4] : (fprid_pkg::SO_MASK & {4{tx_reg[7]}});
      io_oe_reg <= quad_mode_in ? fprid_pkg::QUAD_MASK : fprid_pkg::SO_MASK;
      tx_reg <= tx_last ? tx_src_reg : tx_shifted;
      tx_cnt_reg <= tx_last ? 3'h0 : tx_cnt_reg + 3'h1;
    end
  end

  // Frame-end actions on select rising
  assign end_sleep = cs_rise & (st_reg == fprid_pkg::ST_DONE) & (opcode_reg == fprid_pkg::OP_ENTER_SLEEP) &
                     ~asleep_reg & ~busy_reg;
  assign end_wake = cs_rise & asleep_reg & ~busy_reg & (opcode_reg == fprid_pkg::OP_RELEASE_SLEEP) &
                    ((st_reg == fprid_pkg::ST_DUMMY) | (st_reg == fprid_pkg::ST_SEND));
  assign end_set = cs_rise & (st_reg == fprid_pkg::ST_DONE) & (opcode_reg != fprid_pkg::OP_ENTER_SLEEP);
  assign sleep_done = busy_reg & entering_reg & (tmr_reg == fprid_pkg::TMR_LAST);

  // Entry and recovery timer
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      asleep_reg <= 1'h0;
      busy_reg <= 1'h0;
      entering_reg <= 1'h0;
      tmr_reg <= '0;
    end else if (end_sleep) begin
      busy_reg <= 1'h1;
      entering_reg <= 1'h1;
      tmr_reg <= fprid_pkg::SLEEP_TMR_LOAD;
    end else if (end_wake) begin
      busy_reg <= 1'h1;
      entering_reg <= 1'h0;
      tmr_reg <= fprid_pkg::WAKE_TMR_LOAD;
    end else if (busy_reg) begin
      if (tmr_reg == fprid_pkg::TMR_LAST) begin
        busy_reg <= 1'h0;
        asleep_reg <= entering_reg;
      end else begin
        tmr_reg <= tmr_reg - fprid_pkg::TMR_LAST;
      end
    end
  end

  // Parameter registers
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      nv_rd_reg <= fprid_pkg::RD_PARAM_DEFAULT;
      vol_rd_reg <= fprid_pkg::RD_PARAM_DEFAULT;
      nv_ext_reg <= fprid_pkg::EXT_PARAM_DEFAULT;
      vol_ext_reg <= fprid_pkg::EXT_PARAM_DEFAULT;
      reload_reg <= 1'h1;
    end else if (reload_reg || sleep_done) begin
      // Working copies restart from persistent ones, so wrap mode follows the persistent wrap_enable bit
      vol_rd_reg <= nv_rd_reg;
      vol_ext_reg <= nv_ext_reg;
      reload_reg <= 1'h0;
    end else if (end_set) begin
      if (opcode_reg == fprid_pkg::OP_SET_RD_PERSIST) begin
        nv_rd_reg <= param_reg;
        vol_rd_reg <= param_reg;
      end else if ((opcode_reg == fprid_pkg::OP_SET_RD_TEMP_A) || (opcode_reg == fprid_pkg::OP_SET_RD_TEMP_B)) begin
        vol_rd_reg <= param_reg;
      end else if (opcode_reg == fprid_pkg::OP_SET_EXT_PERSIST) begin
        nv_ext_reg <= param_reg[fprid_pkg::EXT_W-1:0];
        vol_ext_reg <= param_reg[fprid_pkg::EXT_W-1:0];
      end else begin
        vol_ext_reg <= param_reg[fprid_pkg::EXT_W-1:0];
      end
    end
  end

  // Field split of the working read register
  assign wif.cur_addr = rd_addr_reg;
  assign wif.wrap_en = vol_rd_reg[fprid_pkg::WRAP_EN_BIT];
  assign wif.wrap_size = vol_rd_reg[fprid_pkg::WRAP_SIZE_LSB +: fprid_pkg::WRAP_SIZE_W];

  // Read address pointer, stepped by the array read logic
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_addr_reg <= '0;
    end else if (rd_start_in && !asleep_reg) begin
      rd_addr_reg <= rd_start_addr_in;
    end else if (rd_step_in && !asleep_reg) begin
      rd_addr_reg <= wif.next_addr;
    end
  end

  // Shared pin role; a dedicated reset pin never follows the select bit
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_reset_reg <= 1'h0;
    end else begin
      pin_reset_reg <= vol_rd_reg[fprid_pkg::PIN_SEL_BIT] & ~strap_s;
    end
  end

  // Outputs straight from flip-flops
  assign io_out = io_out_reg;
  assign io_oe_out = io_oe_reg;
  assign asleep_out = asleep_reg;
  assign busy_out = busy_reg;
  assign read_params_out = vol_rd_reg;
  assign ext_params_out = vol_ext_reg;
  assign shared_pin_reset_out = pin_reset_reg;
  assign rd_addr_out = rd_addr_reg;

  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  localparam int SLP_MAX = fprid_pkg::SLEEP_ENTRY_CYC + 1;
  localparam int WAKE_MAX = fprid_pkg::WAKE_RECOVERY_CYC + 1;

  sequence s_wake_start;
    end_wake;
  endsequence
  sequence s_recovering;
    (asleep_reg && busy_reg) [*2];
  endsequence

  AST_SLEEP_ENTRY: assert property (end_sleep |=> busy_reg ##[1:SLP_MAX] asleep_reg)
    else $error("Sleep state not reached within entry time");
  AST_PARTIAL_NO_SLEEP: assert property (
    (cs_rise && st_reg != fprid_pkg::ST_DONE && !asleep_reg && !busy_reg) |=> !busy_reg)
    else $error("Incomplete frame started a power transition");
  AST_ONLY_RELEASE: assert property (
    (byte_done && st_reg == fprid_pkg::ST_OPC && asleep_reg && !op_is_ab) |=> st_reg == fprid_pkg::ST_IGNORE)
    else $error("Command other than release accepted while asleep");
  AST_WAKE_TIME: assert property (s_wake_start |=> s_recovering ##[1:WAKE_MAX] !asleep_reg)
    else $error("Recovery from sleep not bounded by recovery time");
  AST_WIP_RELEASE: assert property (
    (byte_done && st_reg == fprid_pkg::ST_OPC && op_is_ab && write_in_progress_in)
      |=> st_reg == fprid_pkg::ST_IGNORE)
    else $error("Release opcode accepted during write in progress");
  AST_TEMP_RD: assert property (
    (end_set && !reload_reg && !sleep_done && (opcode_reg == fprid_pkg::OP_SET_RD_TEMP_A ||
      opcode_reg == fprid_pkg::OP_SET_RD_TEMP_B)) |=> (vol_rd_reg == $past(param_reg)) && $stable(nv_rd_reg))
    else $error("Temporary read parameter set misbehaved");
  AST_PERSIST_EXT: assert property (
    (end_set && !reload_reg && !sleep_done && opcode_reg == fprid_pkg::OP_SET_EXT_PERSIST)
      |=> (nv_ext_reg == vol_ext_reg) && (nv_ext_reg == $past(param_reg[fprid_pkg::EXT_W-1:0])))
    else $error("Persistent drive strength set did not update both copies");
  AST_QUERY_RD: assert property (
    (load_query && in_byte == fprid_pkg::OP_QUERY_RD) |=> tx_src_reg == $past(nv_rd_reg))
    else $error("Read parameter query did not return persistent copy");
  AST_WRAP_WINDOW: assert property (
    (rd_step_in && !rd_start_in && !asleep_reg && wif.wrap_en)
      |=> rd_addr_reg[fprid_pkg::ADDR_W-1:fprid_pkg::WIN_MAX_LSB] ==
          $past(rd_addr_reg[fprid_pkg::ADDR_W-1:fprid_pkg::WIN_MAX_LSB]))
    else $error("Wrapped read left its window");
  AST_ID_LOAD: assert property (load_id |=> (tx_src_reg == DEVICE_ID) [*2])
    else $error("Identifier not loaded after dummy bytes");
endmodule

// [verification/fprid_host_model.sv]
// Host controller model driving the serial command link
module fprid_host_model (
  input wire logic clk_in,
  input wire logic quad_in,
  input wire logic [3:0] dout_in,
  output logic sck_out,
  output logic cs_n_out,
  output logic [3:0] io_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    io_out = 4'h0;
  end
  // One beat: fall with data, rise, sample late in high phase
  task automatic beat(input logic [3:0] d, output logic [3:0] q);
    sck_out <= 1'b0;
    io_out <= d;
    repeat (4) @(posedge clk_in);
    sck_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1 q = dout_in;
    @(posedge clk_in);
  endtask
  // Whole frame, MSB first; select rises only after the last byte
  task automatic frame(input logic [31:0] tx, input int n, input int nrd, output logic [7:0] rx);
    logic [3:0] q;
    int w;
    @(posedge clk_in);
    w = quad_in ? 4 : 1;
    rx = 8'h00;
    cs_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    for (int i = 0; i < 8 * n; i += w) beat(w == 4 ? tx[31-i-:4] : {3'h0, tx[31-i]}, q);
    for (int i = 0; i < 8 * nrd; i += w) begin
      beat(4'h0, q);
      rx = (w == 4) ? {rx[3:0], q} : {rx[6:0], q[1]};
    end
    sck_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    cs_n_out <= 1'b1;
    io_out <= ~io_out;
  endtask
endmodule

// [verification/fprid_top_tb.sv]
// Self-checking bench for the sleep, parameter and identify commands
module fprid_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID = 8'h3c; // Arbitrary identifier value
  logic clk = 1'b0, rstn = 1'b0, quad = 1'b0, write_in_progress = 1'b0, strap = 1'b0, st = 1'b0, stp = 1'b0;
  logic sck, csn, slp, bsy, shr;
  logic [3:0] io, dout, oe;
  logic [23:0] sa = 24'h0, ea, ra;
  logic [7:0] rp, rx, d, p;
  logic [2:0] xp;
  logic [31:0] seed = 32'h0000004e;
  logic [3:0] oe_acc = 4'h0; // Enables seen during the present frame
  logic csn_d = 1'h1; // Select one clock ago, finds frame start
  int bad_count = 0, total_checks = 0, cycles = 0;
  fprid_top #(.DEVICE_ID(ID)) i_dut (.ref_clk_in(clk), .resetn_in(rstn), .sck_in(sck), .cs_n_in(csn), .io_in(io),
    .quad_mode_in(quad), .write_in_progress_in(write_in_progress), .dedicated_reset_pin_in(strap), .rd_start_in(st),
    .rd_start_addr_in(sa), .rd_step_in(stp), .io_out(dout), .io_oe_out(oe), .asleep_out(slp), .busy_out(bsy),
    .read_params_out(rp), .ext_params_out(xp), .shared_pin_reset_out(shr), .rd_addr_out(ra));
  fprid_host_model i_host (.clk_in(clk), .quad_in(quad), .dout_in(dout), .sck_out(sck), .cs_n_out(csn),
    .io_out(io));
  initial forever #20 clk = ~clk;
  // Gather every output enable driven while selected, cleared as a frame opens
  always @(posedge clk) begin
    csn_d <= csn;
    if (!csn && csn_d) oe_acc <= 4'h0;
    else if (!csn) oe_acc <= oe_acc | oe;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      wrap_up();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected next read address
  function automatic logic [23:0] nxt(input logic [23:0] a, input logic [7:0] pv);
    logic [23:0] m;
    m = (24'h000008 << pv[1:0]) - 24'h000001;
    return pv[2] ? ((a & ~m) | ((a + 24'h1) & m)) : a + 24'h1;
  endfunction
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [31:0] tx, input int n, input int nrd);
    i_host.frame(tx, n, nrd, rx);
    repeat (7) @(posedge clk);
    #1;
  endtask
  // Load a start address and step every clock
  task automatic walk(input logic [7:0] pv);
    @(posedge clk);
    ea = (pv == 8'h00) ? 24'hfffff0 : 24'(rnd());
    sa <= ea;
    st <= 1'b1;
    @(posedge clk);
    st <= 1'b0;
    stp <= 1'b1;
    repeat (70) begin
      #1 check(ra, ea);
      ea = nxt(ea, pv);
      @(posedge clk);
    end
    stp <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    #1 check(rp, fprid_pkg::RD_PARAM_DEFAULT);
    check(xp, fprid_pkg::EXT_PARAM_DEFAULT);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      quad <= k[0];
      d = 8'(rnd());
      p = 8'(rnd());
      cmd({fprid_pkg::OP_SET_RD_PERSIST, d, 16'h0}, 2, 0);
      check(rp, d);
      check(oe_acc, 4'h0);
      cmd({fprid_pkg::OP_SET_RD_TEMP_B, p, 16'h0}, 2, 0);
      check(rp, p);
      cmd({fprid_pkg::OP_QUERY_RD, 24'h0}, 1, 1);
      check(rx, d);
      check(oe_acc, k[0] ? fprid_pkg::QUAD_MASK : fprid_pkg::SO_MASK);
      check(oe, 4'h0);
      cmd({fprid_pkg::OP_SET_EXT_PERSIST, d, 16'h0}, 2, 0);
      cmd({fprid_pkg::OP_SET_EXT_TEMP, p, 16'h0}, 2, 0);
      check(xp, p[2:0]);
      cmd({fprid_pkg::OP_QUERY_EXT, 24'h0}, 1, 1);
      check(rx, {5'h0, d[2:0]});
      cmd({fprid_pkg::OP_RELEASE_SLEEP, 24'h0}, 4, 2);
      check(rx, ID);
    end
    $display("test registers done");
    cmd({fprid_pkg::OP_SET_RD_TEMP_A, 8'h80, 16'h0}, 2, 0);
    check(shr, 1'b1);
    @(posedge clk);
    strap <= 1'h1;
    repeat (5) @(posedge clk);
    #1 check(shr, 1'b0);
    cmd({fprid_pkg::OP_SET_RD_TEMP_A, 8'h05, 16'h0}, 2, 0);
    cmd({fprid_pkg::OP_ENTER_SLEEP, 24'h0}, 2, 0);
    check({slp, bsy}, 2'b00);
    cmd({fprid_pkg::OP_ENTER_SLEEP, 24'h0}, 1, 0);
    check(bsy, 1'b1);
    repeat (75) @(posedge clk);
    #1 check({slp, bsy}, 2'b10);
    check(rp, d);
    cmd({fprid_pkg::OP_SET_RD_PERSIST, ~d, 16'h0}, 2, 0);
    check(rp, d);
    @(posedge clk);
    write_in_progress <= 1'h1;
    cmd({fprid_pkg::OP_RELEASE_SLEEP, 24'h0}, 1, 0);
    check({slp, bsy}, 2'b10);
    @(posedge clk);
    write_in_progress <= 1'h0;
    cmd({fprid_pkg::OP_RELEASE_SLEEP, 24'h0}, 1, 0);
    check({slp, bsy}, 2'b11);
    repeat (125) @(posedge clk);
    #1 check({slp, bsy}, 2'b00);
    $display("test sleep done");
    for (int k = 0; k < 8; k++) begin
      cmd({k[0] ? fprid_pkg::OP_SET_RD_TEMP_A : fprid_pkg::OP_SET_RD_TEMP_B, 8'(k), 16'h0}, 2, 0);
      check(rp, 8'(k));
      walk(8'(k));
    end
    $display("test wrap done");
    wrap_up();
  end
endmodule
